//--- src/dap_pkg.sv
// Shared types and constants for the acknowledge and precharge guard block.
// Assumes one system clock; all user pins arrive synchronous to it.
package dap_pkg;

    // Programming bits latched at configuration time
    typedef struct packed {
        logic ack_type_select_cfg;
        logic extra_wait_count_cfg;
        logic burst_delay_cfg_b;
        logic burst_delay_cfg_a;
        logic single_delay_cfg_b;
        logic single_delay_cfg_a;
        logic precharge_cfg_bit_b;
        logic precharge_cfg_bit_a;
    } dap_cfg_t;

    // Access sequencer states
    typedef enum logic [2:0] {
        DAP_IDLE,
        DAP_WAIT_ROW,
        DAP_COUNT,
        DAP_ACKED,
        DAP_BURST_GAP,
        DAP_REFRESH
    } dap_state_t;

    localparam int unsigned NUM_BANKS = 4;
    localparam int unsigned CNT_W = 3;
    localparam dap_cfg_t CFG_RESET = '0;

    // Single-access delay codes {b,a}
    localparam logic [1:0] SGL_0T = 2'h0;
    localparam logic [1:0] SGL_HALF = 2'h1;
    localparam logic [1:0] SGL_1T = 2'h2;
    localparam logic [1:0] SGL_1HALF = 2'h3;

    // Burst delay codes {b,a}
    localparam logic [1:0] BST_NOWAIT = 2'h0;
    localparam logic [1:0] BST_0T = 2'h1;
    localparam logic [1:0] BST_HALF = 2'h2;
    localparam logic [1:0] BST_1T = 2'h3;

    // Extra rising edges added while the extra-wait input is held
    localparam logic [2:0] EXTRA_ONE = 3'h1;
    localparam logic [2:0] EXTRA_TWO = 3'h2;

    // Precharge / refresh active time in rising edges, per {b,a}
    localparam logic [2:0] PRE_T0 = 3'h2;
    localparam logic [2:0] PRE_T1 = 3'h2;
    localparam logic [2:0] PRE_T2 = 3'h3;
    localparam logic [2:0] PRE_T3 = 3'h3;
    localparam logic [2:0] ACT_T0 = 3'h2;
    localparam logic [2:0] ACT_T1 = 3'h3;
    localparam logic [2:0] ACT_T2 = 3'h2;
    localparam logic [2:0] ACT_T3 = 3'h4;

    // Counter values after reset: precharge taken as satisfied
    localparam logic [2:0] CNT_SAT = 3'h7;
    localparam logic [2:0] CNT_ZERO = 3'h0;

endpackage : dap_pkg

//--- src/dap_ack_guard.sv
// Acknowledge timing and per-bank row precharge guard for the host port.
// Assumes bus_clk_in is the host bus clock, sampled by the faster system
// clock; all other inputs are synchronous, active-high asserted levels, except reset_n, which is active-low.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Half-cycle, latch/delayed: ack at low phase after row start
// - Half-cycle, strobe non-delayed: low phase after strobe
// - One-cycle, latch/delayed: ack first rise after row start
// - One-cycle, strobe non-delayed: rise after strobe and select
// - One-and-half, latch/delayed: low after first rise
// - One-and-half, strobe non-delayed: low after first rise
// - Low-phase ack: falling edge if high, else direct
// - Row start edge counts zero; strobe setup edge one
// - Burst bits pick behaviour; no-wait keeps ack asserted
// - Zero-delay burst: ack follows column enables
// - Half-cycle burst: reassert on next low phase
// - One-cycle burst: reassert on next rising edge
// - Burst low-phase rule; setup edge counts one
// - Extra-wait input adds one or two rising edges
// - Added edges counted before the low-phase step
// - Extra wait also applies to burst reacknowledge
// - Precharge bits set precharge and refresh active time
// - Per-bank precharge counter; negated request edge is zero
// - Other bank's pending precharge never delays access
// - Precharge measured around refresh row strobe negation
// - Type bit selects acknowledge output, else wait output
// - Single-access delay bits pick one of four delays
// - Zero-delay: ack from row start or directly from strobe
// - Request negation drops ack until next selected access
module dap_ack_guard (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    // Host bus clock sampled as data
    input wire logic bus_clk_in,
    // Configuration
    input wire dap_pkg::dap_cfg_t cfg_in,
    input wire logic cfg_load_in,
    input wire logic strobe_mode_in,
    // Host access signals
    input wire logic chip_select_in,
    input wire logic latch_enable_in,
    input wire logic address_strobe_in,
    input wire logic access_request_in,
    input wire logic [1:0] bank_select_in,
    input wire logic [3:0] column_strobe_enable_in,
    input wire logic extra_wait_request,
    input wire logic refresh_request_in,
    // Outputs
    output logic transfer_ack_out,
    output logic wait_out,
    output logic [3:0] row_strobe_out,
    output logic refresh_active_out
);

    // Saturating increment for edge counters
    function automatic logic [2:0] sat_inc(input logic [2:0] v);
        return (v == dap_pkg::CNT_SAT) ? v : v + 3'h1;
    endfunction

    // Rising edges needed: base plus any extra-wait edges
    function automatic logic [2:0] edges_needed(input logic base_one, input logic extra,
                                                input logic two);
        logic [2:0] add;
        add = 3'h0;
        if (extra) begin
            add = two ? dap_pkg::EXTRA_TWO : dap_pkg::EXTRA_ONE;
        end
        return {2'h0, base_one} + add;
    endfunction

    // Precharge and refresh active times from the two precharge bits
    function automatic logic [2:0] pre_time(input dap_pkg::dap_cfg_t c);
        logic [1:0] sel;
        sel = {c.precharge_cfg_bit_b, c.precharge_cfg_bit_a};
        if (sel == 2'h0) begin
            return dap_pkg::PRE_T0;
        end else if (sel == 2'h1) begin
            return dap_pkg::PRE_T1;
        end else if (sel == 2'h2) begin
            return dap_pkg::PRE_T2;
        end
        return dap_pkg::PRE_T3;
    endfunction

    function automatic logic [2:0] act_time(input dap_pkg::dap_cfg_t c);
        logic [1:0] sel;
        sel = {c.precharge_cfg_bit_b, c.precharge_cfg_bit_a};
        if (sel == 2'h0) begin
            return dap_pkg::ACT_T0;
        end else if (sel == 2'h1) begin
            return dap_pkg::ACT_T1;
        end else if (sel == 2'h2) begin
            return dap_pkg::ACT_T2;
        end
        return dap_pkg::ACT_T3;
    endfunction

    localparam int unsigned NUM_BANKS_L = dap_pkg::NUM_BANKS;

    dap_pkg::dap_state_t state_q, state_d;
    dap_pkg::dap_cfg_t cfg_q, cfg_d;
    logic cfg_ok_q, cfg_ok_d;
    logic bus_clk_q, bus_clk_d;
    logic strobe_q, strobe_d;
    logic req_q, req_d;
    logic burst_q, burst_d;
    logic pend_q, pend_d;
    logic [1:0] bank_q, bank_d;
    logic [2:0] rc_q, rc_d;
    logic [2:0] pre_cnt_q [NUM_BANKS_L];
    logic [2:0] pre_cnt_d [NUM_BANKS_L];
    logic [3:0] row_q, row_d;
    logic ack_q, ack_d;
    logic wait_q, wait_d;
    logic refr_q, refr_d;
    // Derived per-cycle conditions
    logic rise;
    logic low_phase;
    logic start;
    logic ces_any;
    logic req_fall;
    logic [1:0] sgl_code;
    logic [1:0] bst_code;
    logic [2:0] target;
    logic half_step;
    logic ack_ready;
    logic [3:0] bank_ready;

    // Host clock phase and access events
    always_comb begin
        rise = bus_clk_in & ~bus_clk_q;
        low_phase = ~bus_clk_in;
        start = chip_select_in
              & (strobe_mode_in ? address_strobe_in : latch_enable_in) & ~strobe_q;
        ces_any = |column_strobe_enable_in;
        req_fall = req_q & ~access_request_in;
        sgl_code = {cfg_q.single_delay_cfg_b, cfg_q.single_delay_cfg_a};
        bst_code = {cfg_q.burst_delay_cfg_b, cfg_q.burst_delay_cfg_a};
        for (int i = 0; i < NUM_BANKS_L; i++) begin
            bank_ready[i] = pre_cnt_q[i] >= pre_time(cfg_q);
        end
    end

    // Edge target and low-phase step for the current count
    always_comb begin
        if (burst_q) begin
            target = edges_needed(bst_code == dap_pkg::BST_1T, extra_wait_request,
                                  cfg_q.extra_wait_count_cfg);
            half_step = (bst_code == dap_pkg::BST_HALF);
        end else begin
            target = edges_needed(sgl_code[1], extra_wait_request,
                                  cfg_q.extra_wait_count_cfg);
            half_step = sgl_code[0];
        end
        // Edges first, then the low phase: direct if low, else wait for fall
        ack_ready = (rc_q >= target) && (!half_step || low_phase);
    end

    // Sequencer, counters and output next values
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        cfg_ok_d = cfg_ok_q;
        bus_clk_d = bus_clk_in;
        strobe_d = strobe_mode_in ? address_strobe_in : latch_enable_in;
        req_d = access_request_in;
        burst_d = burst_q;
        pend_d = pend_q;
        bank_d = bank_q;
        rc_d = rc_q;
        row_d = row_q;
        ack_d = ack_q;
        refr_d = refr_q;
        // Every bank counts rising edges while its row strobe is off
        for (int i = 0; i < NUM_BANKS_L; i++) begin
            pre_cnt_d[i] = (rise && !row_q[i]) ? sat_inc(pre_cnt_q[i]) : pre_cnt_q[i];
        end
        if (cfg_load_in) begin
            cfg_d = cfg_in;
            cfg_ok_d = 1'b1;
        end

        case (state_q)
            dap_pkg::DAP_IDLE: begin
                if (start) begin
                    bank_d = bank_select_in;
                    burst_d = 1'b0;
                    rc_d = dap_pkg::CNT_ZERO;
                    if (strobe_mode_in && bank_ready[bank_select_in]) begin
                        // Non-delayed strobe access: row starts now, next rise is one
                        row_d[bank_select_in] = 1'b1;
                        state_d = dap_pkg::DAP_COUNT;
                    end else begin
                        state_d = dap_pkg::DAP_WAIT_ROW;
                    end
                end else if (refresh_request_in && rise && (&bank_ready)) begin
                    row_d = 4'hf;
                    rc_d = dap_pkg::CNT_ZERO;
                    refr_d = 1'b1;
                    state_d = dap_pkg::DAP_REFRESH;
                end
            end
            dap_pkg::DAP_WAIT_ROW: begin
                // Latch mode or delayed: row starts on a rise, that rise is zero
                if (rise && bank_ready[bank_q]) begin
                    row_d[bank_q] = 1'b1;
                    rc_d = dap_pkg::CNT_ZERO;
                    state_d = dap_pkg::DAP_COUNT;
                end
            end
            dap_pkg::DAP_COUNT: begin
                if (rise) begin
                    rc_d = sat_inc(rc_q);
                end
                if (req_fall) begin
                    row_d[bank_q] = 1'b0;
                    pre_cnt_d[bank_q] = dap_pkg::CNT_ZERO;
                    ack_d = 1'b0;
                    state_d = dap_pkg::DAP_IDLE;
                end else if (ack_ready) begin
                    ack_d = 1'b1;
                    state_d = dap_pkg::DAP_ACKED;
                end
            end
            dap_pkg::DAP_ACKED: begin
                if (!access_request_in) begin
                    row_d[bank_q] = 1'b0;
                    pre_cnt_d[bank_q] = dap_pkg::CNT_ZERO;
                    ack_d = 1'b0;
                    state_d = dap_pkg::DAP_IDLE;
                end else if (!ces_any && bst_code != dap_pkg::BST_NOWAIT) begin
                    ack_d = 1'b0;
                    state_d = dap_pkg::DAP_BURST_GAP;
                end
            end
            dap_pkg::DAP_BURST_GAP: begin
                if (!access_request_in) begin
                    row_d[bank_q] = 1'b0;
                    pre_cnt_d[bank_q] = dap_pkg::CNT_ZERO;
                    state_d = dap_pkg::DAP_IDLE;
                end else if (ces_any) begin
                    if (bst_code == dap_pkg::BST_0T && !extra_wait_request) begin
                        ack_d = 1'b1;
                        state_d = dap_pkg::DAP_ACKED;
                    end else begin
                        // Enables set up to the next rise, which counts one
                        burst_d = 1'b1;
                        rc_d = dap_pkg::CNT_ZERO;
                        state_d = dap_pkg::DAP_COUNT;
                    end
                end
            end
            dap_pkg::DAP_REFRESH: begin
                if (start) begin
                    // Access arriving during refresh waits for its precharge
                    pend_d = 1'b1;
                    bank_d = bank_select_in;
                    burst_d = 1'b0;
                end
                if (rise) begin
                    rc_d = sat_inc(rc_q);
                    if (sat_inc(rc_q) >= act_time(cfg_q)) begin
                        row_d = 4'h0;
                        for (int i = 0; i < NUM_BANKS_L; i++) begin
                            pre_cnt_d[i] = dap_pkg::CNT_ZERO;
                        end
                        refr_d = 1'b0;
                        pend_d = 1'b0;
                        state_d = (pend_q || start) ? dap_pkg::DAP_WAIT_ROW
                                                    : dap_pkg::DAP_IDLE;
                    end
                end
            end
            default: begin
                state_d = dap_pkg::DAP_IDLE;
            end
        endcase

        // Wait-type output stands in row wait, count and burst gap; not for an access pending in refresh
        wait_d = (state_d == dap_pkg::DAP_WAIT_ROW) || (state_d == dap_pkg::DAP_COUNT)
               || (state_d == dap_pkg::DAP_BURST_GAP);
    end

    // State registers; clock enable freezes everything
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= dap_pkg::DAP_IDLE;
            cfg_q <= dap_pkg::CFG_RESET;
            cfg_ok_q <= 1'b0;
            bus_clk_q <= 1'b0;
            strobe_q <= 1'b0;
            req_q <= 1'b0;
            burst_q <= 1'b0;
            pend_q <= 1'b0;
            bank_q <= 2'h0;
            rc_q <= dap_pkg::CNT_ZERO;
            row_q <= 4'h0;
            ack_q <= 1'b0;
            wait_q <= 1'b0;
            refr_q <= 1'b0;
            for (int i = 0; i < NUM_BANKS_L; i++) begin
                pre_cnt_q[i] <= dap_pkg::CNT_SAT;
            end
        end else if (clock_enable) begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            cfg_ok_q <= cfg_ok_d;
            bus_clk_q <= bus_clk_d;
            strobe_q <= strobe_d;
            req_q <= req_d;
            burst_q <= burst_d;
            pend_q <= pend_d;
            bank_q <= bank_d;
            rc_q <= rc_d;
            row_q <= row_d;
            ack_q <= ack_d;
            wait_q <= wait_d;
            refr_q <= refr_d;
            for (int i = 0; i < NUM_BANKS_L; i++) begin
                pre_cnt_q[i] <= pre_cnt_d[i];
            end
        end
    end

    // Output type chosen at programming time; no ack or wait before configuration
    always_comb begin
        transfer_ack_out = ack_q & cfg_ok_q & cfg_q.ack_type_select_cfg;
        wait_out = wait_q & cfg_ok_q & ~cfg_q.ack_type_select_cfg;
        row_strobe_out = row_q;
        refresh_active_out = refr_q;
    end

endmodule // dap_ack_guard

`default_nettype wire

//--- test/dap_ack_guard_monitor.sv
// Checker for acknowledge timing and row strobe behaviour of the guard.
// Assumes it is bound into dap_ack_guard and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dap_ack_guard_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    // Watched inputs
    input wire logic bus_clk_in,
    input wire dap_pkg::dap_cfg_t cfg_in,
    input wire logic cfg_load_in,
    input wire logic access_request_in,
    input wire logic [3:0] column_strobe_enable_in,
    // Watched outputs
    input wire logic transfer_ack_out,
    input wire logic [3:0] row_strobe_out,
    input wire logic refresh_active_out
);
    dap_pkg::dap_cfg_t cfg_q;
    dap_pkg::dap_cfg_t cfg_d;
    logic gap_q;
    logic gap_d;
    logic low_need;
    logic [1:0] burst_code;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Shadow of programming bits; gap marks a burst pause in this access
    always_comb begin
        cfg_d = cfg_q;
        gap_d = gap_q;
        if (cfg_load_in && clock_enable) begin
            cfg_d = cfg_in;
        end
        if (!access_request_in) begin
            gap_d = 1'b0;
        end else if (transfer_ack_out && column_strobe_enable_in == 4'h0) begin
            gap_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cfg_q <= dap_pkg::CFG_RESET;
            gap_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            gap_q <= gap_d;
        end
    end

    // Half options wait for a low bus clock sample before acknowledging
    assign burst_code = {cfg_q.burst_delay_cfg_b, cfg_q.burst_delay_cfg_a};
    assign low_need = gap_q ? (burst_code == dap_pkg::BST_HALF) : cfg_q.single_delay_cfg_a;

    chk_reset_quiet: assert property ($rose(reset_n) |-> !transfer_ack_out && row_strobe_out == 4'h0)
        else $error("outputs active right after reset");
    chk_req_drop: assert property ($fell(access_request_in) |-> ##[1:3] !transfer_ack_out)
        else $error("ack kept after request fell");
    chk_row_end: assert property ($fell(access_request_in) |-> ##[1:4] row_strobe_out == 4'h0)
        else $error("row strobe kept after access end");
    chk_ack_after_row: assert property ($rose(transfer_ack_out) |-> row_strobe_out != 4'h0)
        else $error("ack without a row strobe");
    chk_type_gate: assert property ($rose(transfer_ack_out) |-> cfg_q.ack_type_select_cfg)
        else $error("ack raised with wait type selected");
    chk_low_phase: assert property ($rose(transfer_ack_out) && low_need |-> !$past(bus_clk_in))
        else $error("half option ack outside low phase");
    chk_burst_drop: assert property (transfer_ack_out && access_request_in &&
        column_strobe_enable_in == 4'h0 && burst_code != dap_pkg::BST_NOWAIT |-> ##[1:3] !transfer_ack_out)
        else $error("ack not dropped in burst gap");
    chk_nowait_hold: assert property (transfer_ack_out && access_request_in &&
        $past(access_request_in) && burst_code == dap_pkg::BST_NOWAIT |=> transfer_ack_out)
        else $error("no-wait burst dropped ack");
    chk_one_row: assert property (!refresh_active_out |-> $onehot0(row_strobe_out))
        else $error("more than one row strobe in access");
endmodule // dap_ack_guard_monitor

bind dap_ack_guard dap_ack_guard_monitor dap_ack_guard_monitor_i (
    .clock, .reset_n, .clock_enable, .bus_clk_in, .cfg_in, .cfg_load_in,
    .access_request_in, .column_strobe_enable_in, .transfer_ack_out,
    .row_strobe_out, .refresh_active_out
);
`default_nettype wire

//--- test/dap_host_model.sv
// Host side model: free-running bus clock and a held access request.
// Assumes the bench raises go after a falling edge and drops it after ack.
`timescale 1ns/1ps
`default_nettype none
module dap_host_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bench control
    input wire logic go,
    // Host bus side
    output logic bus_clk = 1'b0,
    output logic strobe = 1'b0,
    output logic request = 1'b0
);
    logic [2:0] phase_q;
    logic go_q;
    logic run_q;

    // Go and reset taken on the rising edge so bench and model never race
    always_ff @(posedge clock) begin
        go_q <= go;
        run_q <= reset_n;
    end

    // Bus clock four cycles high, four low; pins move on falling edges
    always_ff @(negedge clock) begin
        if (!run_q) begin
            phase_q <= 3'h0;
            bus_clk <= 1'b0;
            strobe <= 1'b0;
            request <= 1'b0;
        end else begin
            phase_q <= phase_q + 3'h1;
            bus_clk <= phase_q[2];
            strobe <= go_q;
            request <= go_q;
        end
    end
endmodule // dap_host_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the acknowledge and precharge guard.
// Assumes the host model and the bound monitor are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic md;
        logic [1:0] sgl;
        logic ew;
        logic cnt;
        logic [1:0] er;
        logic [1:0] lo;
    } dap_row_t;
    logic clock, reset_n, go, cfg_load_in, strobe_mode_in, extra_wait_request;
    logic bus_clk_in, host_strobe, access_request_in, transfer_ack_out, wait_out;
    logic refresh_request_in, refresh_active_out;
    logic [1:0] bank_select_in;
    logic [3:0] column_strobe_enable_in, row_strobe_out;
    logic [2:0] hist;
    dap_pkg::dap_cfg_t cfg_in;
    int rises, bad_count, check_count;
    // Mode, single code, extra wait, count bit, rises, phase (1x = skip)
    dap_row_t rows [11] = '{'{0,0,0,0,0,1}, '{0,1,0,0,0,0}, '{0,2,0,0,1,1},
        '{0,3,0,0,1,0}, '{1,0,0,0,0,2}, '{1,1,0,0,0,0}, '{1,2,0,0,1,1},
        '{1,3,0,0,1,0}, '{0,1,1,0,1,0}, '{0,2,1,1,3,1}, '{1,0,1,1,2,1}};

    dap_ack_guard dap_ack_guard_i (
        .clock, .reset_n, .clock_enable(1'b1), .bus_clk_in, .cfg_in, .cfg_load_in,
        .strobe_mode_in, .chip_select_in(host_strobe),
        .latch_enable_in(host_strobe & ~strobe_mode_in),
        .address_strobe_in(host_strobe & strobe_mode_in), .access_request_in,
        .bank_select_in, .column_strobe_enable_in, .extra_wait_request,
        .refresh_request_in, .transfer_ack_out, .wait_out, .row_strobe_out,
        .refresh_active_out
    );
    dap_host_model dap_host_model_i (
        .clock, .reset_n, .go, .bus_clk(bus_clk_in), .strobe(host_strobe),
        .request(access_request_in)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One cycle; bus clock history as the design sampled it
    task automatic step();
        @(negedge clock);
        hist = {hist[1:0], bus_clk_in};
        if (hist[1:0] == 2'b01) rises++;
    endtask

    task automatic load(input logic typ, input logic cnt, input logic [1:0] bst,
            input logic [1:0] sgl);
        cfg_in = dap_pkg::dap_cfg_t'({typ, cnt, bst, sgl, 2'h3});
        cfg_load_in = 1'b1;
        step();
        cfg_load_in = 1'b0;
    endtask

    task automatic wait_row(input logic [1:0] bk, input logic val);
        for (int t = 0; t < 300 && row_strobe_out[bk] !== val; t++) step();
    endtask

    // Counts bus rises up to the ack; phase is the sample at the ack edge
    task automatic wait_ack(input int er, input logic [1:0] lo);
        rises = 0;
        for (int t = 0; t < 300 && transfer_ack_out !== 1'b1; t++) step();
        check("ack_rises", 8'(rises), 8'(er));
        if (!lo[1]) check("ack_phase", {7'h0, hist[0]}, {7'h0, lo[0]});
    endtask

    // Start aligned just after a bus rise so edge counts are exact
    task automatic access(input logic [1:0] bk, input int er, input logic [1:0] lo);
        while (hist[1:0] !== 2'b01) step();
        bank_select_in = bk;
        go = 1'b1;
        wait_row(bk, 1'b1);
        wait_ack(er, lo);
    endtask

    task automatic finish_access();
        go = 1'b0;
        repeat (6) step();
        check("ack_end", {7'h0, transfer_ack_out}, 8'h0);
        repeat (20) step();
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run is under two thousand cycles; over fifteen times that means a hang
    initial begin
        repeat (30000) @(posedge clock);
        bad_count++;
        give_verdict();
    end

    initial begin
        {reset_n, go, cfg_load_in, strobe_mode_in, extra_wait_request, refresh_request_in} = 6'h0;
        {bank_select_in, hist, rises, bad_count, check_count} = '0;
        column_strobe_enable_in = 4'hf;
        cfg_in = dap_pkg::CFG_RESET;
        repeat (12) step();
        reset_n = 1'b1;
        // Single access delays in both modes, with and without extra wait
        foreach (rows[i]) begin
            load(1'b1, rows[i].cnt, dap_pkg::BST_NOWAIT, rows[i].sgl);
            strobe_mode_in = rows[i].md;
            extra_wait_request = rows[i].ew;
            access(2'(i), int'(rows[i].er), rows[i].lo);
            finish_access();
            extra_wait_request = 1'b0;
        end
        // Every burst code, the last one again with extra wait
        strobe_mode_in = 1'b0;
        for (int b = 0; b < 5; b++) begin
            load(1'b1, 1'b0, (b == 4) ? dap_pkg::BST_1T : 2'(b), dap_pkg::SGL_0T);
            access(2'(b), 0, 2'h1);
            column_strobe_enable_in = 4'h0;
            repeat (8) step();
            check("burst_gap", {7'h0, transfer_ack_out}, 8'(b == 0));
            extra_wait_request = (b == 4);
            while (hist[1:0] !== 2'b01) step();
            column_strobe_enable_in = 4'h5;
            if (b != 0) wait_ack((b > 2) ? b - 2 : 0, (b == 2) ? 2'h0 : 2'h2);
            finish_access();
            extra_wait_request = 1'b0;
            column_strobe_enable_in = 4'hf;
        end
        // Same bank waits out precharge, another bank does not
        access(2'h2, 0, 2'h1);
        for (int k = 0; k < 2; k++) begin
            go = 1'b0;
            rises = 0;
            wait_row(2'h2, 1'b0);
            bank_select_in = 2'h2 + 2'(k);
            go = 1'b1;
            wait_row(bank_select_in, 1'b1);
            if (k == 0) check("pre_same", 8'(rises >= int'(dap_pkg::PRE_T3)), 8'h1);
            else check("pre_other", 8'(rises <= 2), 8'h1);
            wait_ack(0, 2'h1);
        end
        finish_access();
        // Refresh holds every row for the active time; precharge then gates an access
        refresh_request_in = 1'b1;
        for (int t = 0; t < 300 && refresh_active_out !== 1'b1; t++) step();
        check("refresh_rows", {4'h0, row_strobe_out}, 8'h0f);
        rises = 0;
        for (int t = 0; t < 300 && refresh_active_out !== 1'b0; t++) step();
        refresh_request_in = 1'b0;
        check("refresh_rises", 8'(rises), 8'(dap_pkg::ACT_T3));
        rises = 0;
        bank_select_in = 2'h1;
        go = 1'b1;
        wait_row(2'h1, 1'b1);
        check("pre_refresh", 8'(rises >= int'(dap_pkg::PRE_T3)), 8'h1);
        wait_ack(0, 2'h1);
        finish_access();
        // Wait type selected: wait stands while held off, no ack at all
        load(1'b0, 1'b0, dap_pkg::BST_NOWAIT, dap_pkg::SGL_0T);
        go = 1'b1;
        repeat (3) step();
        check("wait_held", {7'h0, wait_out}, 8'h1);
        repeat (37) step();
        check("wait_type", {7'h0, transfer_ack_out}, 8'h0);
        check("wait_done", {7'h0, wait_out}, 8'h0);
        finish_access();
        // Reset in mid-access, then an unprogrammed access
        load(1'b1, 1'b0, dap_pkg::BST_NOWAIT, dap_pkg::SGL_1T);
        access(2'h1, 1, 2'h1);
        reset_n = 1'b0;
        go = 1'b0;
        repeat (12) step();
        check("reset_out", {2'h0, wait_out, transfer_ack_out, row_strobe_out}, 8'h0);
        reset_n = 1'b1;
        go = 1'b1;
        repeat (40) step();
        check("unprogrammed", {7'h0, transfer_ack_out}, 8'h0);
        finish_access();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
